// ### ism_pkg.sv
// package: register map, field layout, line map and carrier types of the irq source mapping block
package ism_pkg;
    localparam int          NUM_LINES  = 32;
    localparam int          PRIO_W     = 2;
    localparam int          MASK_W     = 3;
    localparam int          VEC_W      = 6;
    localparam int          SYNC_W     = 6;
    // lines 0, 8..12, 16..21, 24..26, 30, 31 are wired; the rest stay dark
    localparam logic [31:0] LINE_VALID = 32'hC73F_1F01;
    localparam logic [7:0]  OFS_STATUS = 8'h00;
    localparam logic [7:0]  OFS_ENABLE = 8'h04;
    localparam logic [7:0]  OFS_CLEAR  = 8'h08;
    localparam logic [7:0]  OFS_SWSET  = 8'h0C;
    localparam logic [7:0]  OFS_PRIO_L = 8'h10;
    localparam logic [7:0]  OFS_PRIO_H = 8'h14;
    localparam logic [7:0]  OFS_MASK   = 8'h18;
    localparam logic [7:0]  OFS_RAW    = 8'h1C;
    localparam logic [7:0]  OFS_EXC    = 8'h20;
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [63:0] RST_PRIO   = 64'h0000_0000_0000_0000;
    localparam logic [2:0]  RST_MASK   = 3'h0;
    // vector numbers handed to the core for the two system exceptions
    localparam logic [5:0]  VEC_EXC0   = 6'h20;
    localparam logic [5:0]  VEC_EXC1   = 6'h21;
    localparam int          L_START0   = 0;
    localparam int          L_START8   = 8;
    localparam int          L_START12  = 12;
    localparam int          L_T16A     = 16;
    localparam int          L_T16B     = 17;
    localparam int          L_T32A     = 18;
    localparam int          L_T32B     = 19;
    localparam int          L_SPI      = 20;
    localparam int          L_UART     = 21;
    localparam int          L_ADC      = 24;
    localparam int          L_WDT      = 25;
    localparam int          L_BOD      = 26;
    localparam int          L_GPIO1    = 30;
    localparam int          L_GPIO0    = 31;

    typedef struct packed {
        logic [2:0] timer16_first;
        logic [1:0] timer16_second;
        logic [3:0] timer32_first;
        logic [3:0] timer32_second;
        logic       timer32_second_cap0;
        logic [3:0] serial_periph_ctrl;   // txhalf, rxhalf, rxtimeout, rxoverrun
        logic       rx_line_status_irq;
        logic       tx_holding_empty_irq;
        logic       rx_data_avail_irq;
        logic       char_timeout_irq;
        logic       autobaud_end_irq;
        logic       autobaud_timeout_irq;
        logic       adc_end_of_conv;
        logic       watchdog_irq;
        logic       brownout_detector;
        logic       gpio_port1_irq;
        logic       gpio_port0_irq;
    } ism_src_t;

    typedef struct packed {
        logic       port0_pin0;
        logic [3:0] port0_pin8_11;        // bit k is port 0 pin 8+k
        logic       port1_pin0;
    } ism_pins_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ism_apb_req_t;

    typedef struct packed {
        logic [31:0] enable;
        logic [31:0] pending;
        logic [63:0] prio;
        logic [2:0]  mask;
        logic [1:0]  exc_pend;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        req;
        logic [5:0]  vec;
        logic        irq_out;
    } ism_state_t;
endpackage

// ### ism_line_map.sv
// source to line mapping with wake-up pin synchronisers
`timescale 1ns/1ps
module ism_line_map (
    input  wire logic              clock,    // system clock
    input  wire logic              sys_rst,  // async reset, active high
    input  wire ism_pkg::ism_src_t src,      // peripheral sources, same clock
    input  wire ism_pkg::ism_pins_t pins,    // wake-up pins, asynchronous
    output logic [31:0]            lines     // raw request lines
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
    } ism_sync_t;

    ism_sync_t st_r;
    ism_sync_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // each line is the or of its sources; unlisted lines stay zero
    always_comb begin
        lines = 32'h0000_0000;
        lines[ism_pkg::L_START0] = st_r.s2[5];
        lines[ism_pkg::L_START8 +: 4] = st_r.s2[4:1];
        lines[ism_pkg::L_START12] = st_r.s2[0];
        lines[ism_pkg::L_T16A] = |src.timer16_first;
        lines[ism_pkg::L_T16B] = |src.timer16_second;
        lines[ism_pkg::L_T32A] = |src.timer32_first;
        lines[ism_pkg::L_T32B] = (|src.timer32_second) | src.timer32_second_cap0;
        lines[ism_pkg::L_SPI] = |src.serial_periph_ctrl;
        lines[ism_pkg::L_UART] = src.rx_line_status_irq | src.tx_holding_empty_irq
            | src.rx_data_avail_irq | src.char_timeout_irq
            | src.autobaud_end_irq | src.autobaud_timeout_irq;
        lines[ism_pkg::L_ADC] = src.adc_end_of_conv;
        lines[ism_pkg::L_WDT] = src.watchdog_irq;
        lines[ism_pkg::L_BOD] = src.brownout_detector;
        lines[ism_pkg::L_GPIO1] = src.gpio_port1_irq;
        lines[ism_pkg::L_GPIO0] = src.gpio_port0_irq;
    end

    AST_PIN_SYNC: assert property (@(posedge clock) disable iff (sys_rst)
        ##2 lines[ism_pkg::L_START0] == $past(pins.port0_pin0, 2))
        else $error("wake-up line 0 not two cycles behind its pin");
    AST_UART_OR: assert property (@(posedge clock) disable iff (sys_rst)
        src.autobaud_timeout_irq |-> lines[ism_pkg::L_UART])
        else $error("uart line missed a source");
    AST_T32B_CAP: assert property (@(posedge clock) disable iff (sys_rst)
        (src.timer32_second == 4'h0 && !src.timer32_second_cap0) |-> !lines[ism_pkg::L_T32B])
        else $error("timer line 19 high with no source");
endmodule

// ### ism_arbiter.sv
// picks the winning request among eligible lines and exceptions
`timescale 1ns/1ps
module ism_arbiter (
    input  wire logic [31:0] pend_en,  // pending and enabled lines
    input  wire logic [63:0] prio,     // two bits per line
    input  wire logic [2:0]  mask,     // current masking level
    input  wire logic [1:0]  exc,      // pending system exceptions
    output logic             any,      // something wins
    output logic [5:0]       vec       // winning vector
);
    logic [31:0] elig;

    // a line passes only when its level, counted from one, exceeds the mask
    genvar g;
    generate
        for (g = 0; g < ism_pkg::NUM_LINES; g++) begin : g_elig
            assign elig[g] = pend_en[g] && ({1'b0, prio[2*g +: 2]} + 3'h1 > mask);
        end
    endgenerate

    always_comb begin
        logic [2:0] best;
        best = 3'h0;
        any  = 1'b0;
        vec  = 6'h00;
        // descending scan with >= lets the lower line number win a tie
        for (int i = ism_pkg::NUM_LINES - 1; i >= 0; i--) begin
            if (elig[i] && ({1'b0, prio[2*i +: 2]} >= best || !any)) begin
                best = {1'b0, prio[2*i +: 2]};
                any  = 1'b1;
                vec  = 6'(i);
            end
        end
        // exceptions sit above every line and ignore the mask
        if (exc[1]) begin
            any = 1'b1;
            vec = ism_pkg::VEC_EXC1;
        end
        if (exc[0]) begin
            any = 1'b1;
            vec = ism_pkg::VEC_EXC0;
        end
    end
endmodule

// ### ism_top.sv
// irq source mapping: apb registers, pending state and request to the core
`timescale 1ns/1ps
// Summary of operation
// - thirty-two vectored lines, numbered 0 to 31
// - four priority levels, mask at or below level
// - system exceptions handled above peripheral lines
// - line is or of its sources
// - lines 0 and 8-12 follow wake-up pins
// - only wired lines; reserved lines never assert
// - timer matches and capture on lines 16-19
// - serial peripheral sources or onto line 20
// - uart sources or onto line 21
// - adc 24, watchdog 25, brown-out 26
// - gpio port 1 on 30, port 0 on 31
module ism_top (
    input  wire logic                  clock,     // system clock, 40 MHz
    input  wire logic                  sys_rst,   // async reset, active high
    input  wire logic                  psel,      // apb select
    input  wire logic                  penable,   // apb access phase
    input  wire logic                  pwrite,    // apb write
    input  wire logic [7:0]            paddr,     // apb byte address
    input  wire logic [31:0]           pwdata,    // apb write data
    output logic [31:0]                prdata,    // apb read data
    output logic                       pready,    // apb ready
    output logic                       pslverr,   // apb error, unmapped
    input  wire ism_pkg::ism_src_t     src,       // peripheral sources
    input  wire ism_pkg::ism_pins_t    pins,      // wake-up pins
    input  wire logic [1:0]            sys_exc,   // system exception events
    input  wire logic                  irq_ack,   // core takes vector, pulse
    output logic                       irq_req,   // request to core
    output logic [5:0]                 irq_vec,   // vector of request
    output logic                       irq_out    // enabled status bit set
);
    ism_pkg::ism_state_t   st_r;
    ism_pkg::ism_state_t   st_nxt;
    ism_pkg::ism_apb_req_t bus;
    logic [31:0]           raw;
    logic                  arb_any;
    logic [5:0]            arb_vec;
    logic                  wr_en;
    logic                  setup;
    logic [31:0]           clr_bits;
    logic [31:0]           set_bits;
    logic [1:0]            exc_clr;

    assign bus = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    ism_line_map u_map (
        .clock   (clock),
        .sys_rst (sys_rst),
        .src     (src),
        .pins    (pins),
        .lines   (raw)
    );

    ism_arbiter u_arb (
        .pend_en (st_r.pending & st_r.enable),
        .prio    (st_r.prio),
        .mask    (st_r.mask),
        .exc     (st_r.exc_pend),
        .any     (arb_any),
        .vec     (arb_vec)
    );

    // write lands only at the access edge where ready is seen
    assign wr_en = bus.psel && bus.penable && st_r.pready && bus.pwrite;
    assign setup = bus.psel && !bus.penable;

    always_comb begin
        st_nxt   = st_r;
        clr_bits = 32'h0000_0000;
        set_bits = raw & ism_pkg::LINE_VALID;
        exc_clr  = 2'h0;
        if (wr_en && bus.paddr == ism_pkg::OFS_CLEAR) begin
            clr_bits = bus.pwdata;
        end
        if (wr_en && bus.paddr == ism_pkg::OFS_SWSET) begin
            set_bits = set_bits | (bus.pwdata & ism_pkg::LINE_VALID);
        end
        if (wr_en && bus.paddr == ism_pkg::OFS_EXC) begin
            exc_clr = bus.pwdata[1:0];
        end
        // acknowledge retires the vector that was offered
        if (irq_ack && st_r.req) begin
            if (st_r.vec == ism_pkg::VEC_EXC0) begin
                exc_clr[0] = 1'b1;
            end else if (st_r.vec == ism_pkg::VEC_EXC1) begin
                exc_clr[1] = 1'b1;
            end else begin
                clr_bits[st_r.vec[4:0]] = 1'b1;
            end
        end
        // a set arriving with its clear survives
        st_nxt.pending  = (st_r.pending & ~clr_bits) | set_bits;
        st_nxt.exc_pend = (st_r.exc_pend & ~exc_clr) | sys_exc;
        if (wr_en) begin
            unique case (bus.paddr)
                ism_pkg::OFS_ENABLE: st_nxt.enable = bus.pwdata & ism_pkg::LINE_VALID;
                ism_pkg::OFS_PRIO_L: st_nxt.prio[31:0] = bus.pwdata;
                ism_pkg::OFS_PRIO_H: st_nxt.prio[63:32] = bus.pwdata;
                ism_pkg::OFS_MASK:   st_nxt.mask = bus.pwdata[2:0];
                default: ;
            endcase
        end
        // zero-wait slave: answer prepared in setup, shown in access
        st_nxt.pready  = setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h0000_0000;
        if (setup) begin
            unique case (bus.paddr)
                ism_pkg::OFS_STATUS: st_nxt.prdata = st_r.pending;
                ism_pkg::OFS_ENABLE: st_nxt.prdata = st_r.enable;
                ism_pkg::OFS_CLEAR:  st_nxt.prdata = 32'h0000_0000;
                ism_pkg::OFS_SWSET:  st_nxt.prdata = 32'h0000_0000;
                ism_pkg::OFS_PRIO_L: st_nxt.prdata = st_r.prio[31:0];
                ism_pkg::OFS_PRIO_H: st_nxt.prdata = st_r.prio[63:32];
                ism_pkg::OFS_MASK:   st_nxt.prdata = {29'h0000_0000, st_r.mask};
                ism_pkg::OFS_RAW:    st_nxt.prdata = raw & ism_pkg::LINE_VALID;
                ism_pkg::OFS_EXC:    st_nxt.prdata = {30'h0000_0000, st_r.exc_pend};
                default:             st_nxt.pslverr = 1'b1;
            endcase
        end
        st_nxt.req     = arb_any;
        st_nxt.vec     = arb_vec;
        st_nxt.irq_out = |(st_r.pending & st_r.enable);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r        <= '0;
            st_r.enable <= ism_pkg::RST_ENABLE;
            st_r.prio   <= ism_pkg::RST_PRIO;
            st_r.mask   <= ism_pkg::RST_MASK;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq_req = st_r.req;
    assign irq_vec = st_r.vec;
    assign irq_out = st_r.irq_out;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_RESERVED_DARK: assert property (
        (st_r.pending & ~ism_pkg::LINE_VALID) == 32'h0000_0000)
        else $error("reserved line became pending");
    AST_SW_SET: assert property (
        (wr_en && paddr == ism_pkg::OFS_SWSET && pwdata[ism_pkg::L_ADC])
        |=> st_r.pending[ism_pkg::L_ADC])
        else $error("software set did not make line pending");
    AST_IRQ_LEVEL: assert property (
        ##1 irq_out == $past(|(st_r.pending & st_r.enable)))
        else $error("interrupt output does not follow enabled status");
    AST_MASK_LEVEL: assert property (
        // index by the vector shown now, with the levels as they stood when it won
        (irq_req && !irq_vec[5]) |->
        {1'b0, 2'($past(st_r.prio) >> {irq_vec[4:0], 1'b0})} + 3'h1 > $past(st_r.mask))
        else $error("masked line offered to the core");
    AST_EXC_FIRST: assert property (
        (|st_r.exc_pend) |=> (irq_req && irq_vec[5]))
        else $error("exception not offered ahead of lines");
    AST_VEC_RANGE: assert property (
        irq_req |-> (irq_vec < 6'h22))
        else $error("vector outside 0 to 33");
    AST_PEND_HOLD: assert property (
        (st_r.pending[ism_pkg::L_WDT] && !irq_ack && !wr_en) |=> st_r.pending[ism_pkg::L_WDT])
        else $error("pending bit lost without a clear");
    AST_APB_READY: assert property (
        (psel && !penable) |=> (pready ##1 !pready))
        else $error("apb ready not exactly one access cycle");
    AST_RAW_PEND: assert property (
        raw[ism_pkg::L_SPI] |=> st_r.pending[ism_pkg::L_SPI])
        else $error("asserted line did not become pending");
endmodule

// ### ism_core_model.sv
// core side model: takes the offered vector after a chosen delay and pulses the acknowledge
`timescale 1ns/1ps
module ism_core_model (
    input  wire logic       clock,     // system clock
    input  wire logic       sys_rst,   // async reset, active high
    input  wire logic       irq_req,   // request from the controller
    input  wire logic [5:0] irq_vec,   // vector offered
    input  wire logic       en,        // core accepts interrupts
    input  wire logic [1:0] dly,       // cycles before taking the vector
    output logic            irq_ack,   // one cycle acknowledge
    output logic            taken_stb, // vector taken, one cycle
    output logic [5:0]      taken_vec  // vector that was taken
);
    logic [1:0] wait_r;
    logic [1:0] hold_r;
    logic       busy_r;

    // hold off three edges after an ack: pending clears on the next edge and
    // the request only shows the new winner one edge later
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack   <= 1'b0;
            taken_stb <= 1'b0;
            taken_vec <= 6'h00;
            wait_r    <= 2'h0;
            hold_r    <= 2'h0;
            busy_r    <= 1'b0;
        end else begin
            irq_ack   <= 1'b0;
            // report what stands on the vector lines while the ack is seen
            taken_stb <= irq_ack;
            if (irq_ack) begin
                taken_vec <= irq_vec;
            end
            if (hold_r != 2'h0) begin
                hold_r <= hold_r - 2'h1;
            end else if (busy_r) begin
                if (wait_r != 2'h0) begin
                    wait_r <= wait_r - 2'h1;
                end else begin
                    irq_ack   <= 1'b1;
                    busy_r    <= 1'b0;
                    hold_r    <= 2'h3;
                end
            end else if (en && irq_req) begin
                busy_r <= 1'b1;
                wait_r <= dly;
            end
        end
    end
endmodule

// ### tb_top.sv
// testbench: apb driver, source stimulus and vector scoreboard of the irq source mapping block
`timescale 1ns/1ps
module tb_top;
    logic               clock, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, seed, rv, rdv;
    ism_pkg::ism_src_t  src;
    ism_pkg::ism_pins_t pins;
    logic [1:0]         sys_exc, core_dly;
    logic               irq_ack, irq_req, irq_out, core_en, taken_stb, errv;
    logic [5:0]         irq_vec, taken_vec;
    logic [34:0]        v;
    int                 fail_count, n_compared;
    logic [5:0]         exp_q[$];

    ism_top DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
        .pins(pins), .sys_exc(sys_exc), .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec),
        .irq_out(irq_out));
    ism_core_model core (.clock(clock), .sys_rst(sys_rst), .irq_req(irq_req), .irq_vec(irq_vec),
        .en(core_en), .dly(core_dly), .irq_ack(irq_ack), .taken_stb(taken_stb), .taken_vec(taken_vec));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // {src, pins} to the expected raw line levels
    function automatic logic [31:0] map_in(input logic [34:0] s);
        logic [31:0] m;
        m       = 32'h0000_0000;
        m[16]   = |s[34:32];
        m[17]   = |s[31:30];
        m[18]   = |s[29:26];
        m[19]   = |s[25:21];
        m[20]   = |s[20:17];
        m[21]   = |s[16:11];
        m[24]   = s[10];
        m[25]   = s[9];
        m[26]   = s[8];
        m[30]   = s[7];
        m[31]   = s[6];
        m[0]    = s[5];
        m[11:8] = s[4:1];
        m[12]   = s[0];
        return m;
    endfunction

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            check("pready", 32'(pready), 32'h0000_0001);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(n, r, exp);
    endtask

    // slow or prompt core, picked at random per run of the queue
    task automatic drain();
        int k;
        rv = xs();
        core_dly <= rv[1:0];
        core_en  <= 1'b1;
        k = 0;
        while (exp_q.size() != 0 && k < 300) begin
            @(posedge clock);
            k++;
        end
        check("queue", 32'(exp_q.size()), 32'h0000_0000);
        repeat (4) @(posedge clock);
        core_en <= 1'b0;
    endtask

    always @(posedge clock) begin
        if (taken_stb === 1'b1)
            check("vector", 32'(taken_vec), exp_q.size() != 0 ? 32'(exp_q.pop_front()) : 32'hFFFF_FFFF);
    end

    initial begin
        repeat (30000) @(posedge clock);
        fail_count++;
        conclude();
    end

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        src = '0;
        pins = '0;
        sys_exc = 2'h0;
        core_en = 1'b0;
        core_dly = 2'h0;
        seed = 32'h0001_73E3;
        fail_count = 0;
        n_compared = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk("enable", ism_pkg::OFS_ENABLE, ism_pkg::RST_ENABLE);
        rd_chk("prio_l", ism_pkg::OFS_PRIO_L, ism_pkg::RST_PRIO[31:0]);
        rd_chk("mask", ism_pkg::OFS_MASK, {29'h0, ism_pkg::RST_MASK});
        rd_chk("status", ism_pkg::OFS_STATUS, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, rdv, errv);
        check("wr_err", 32'(errv), 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0000_0000, rdv, errv);
        check("rd_err", {errv, rdv[30:0]}, 32'h8000_0000);
        wr(ism_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
        rd_chk("enable", ism_pkg::OFS_ENABLE, ism_pkg::LINE_VALID);
        wr(ism_pkg::OFS_PRIO_H, 32'h002D_0000);
        rd_chk("prio_h", ism_pkg::OFS_PRIO_H, 32'h002D_0000);
        $display("test registers done");
        // single-bit walk first, then random mixes
        for (int i = 0; i < 51; i++) begin
            rv = xs();
            v = (i < 35) ? (35'h1 << i) : {rv[2:0], xs()};
            {src, pins} <= v;
            repeat (5) @(posedge clock);
            rd_chk("raw", ism_pkg::OFS_RAW, map_in(v));
        end
        {src, pins} <= 35'h0;
        repeat (5) @(posedge clock);
        wr(ism_pkg::OFS_CLEAR, 32'hFFFF_FFFF);
        wr(ism_pkg::OFS_ENABLE, 32'hC700_0000);
        rd_chk("status", ism_pkg::OFS_STATUS, 32'h0000_0000);
        $display("test line map done");
        src.watchdog_irq <= 1'b1;
        @(posedge clock);
        src.watchdog_irq <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("irq_out", 32'(irq_out), 32'h0000_0001);
        check("irq_vec", 32'(irq_vec), 32'd25);
        exp_q.push_back(6'd25);
        drain();
        check("irq_out", 32'(irq_out), 32'h0000_0000);
        $display("test single line done");
        wr(ism_pkg::OFS_SWSET, 32'hC700_0000);
        exp_q = '{6'd25, 6'd26, 6'd24, 6'd30, 6'd31};
        drain();
        wr(ism_pkg::OFS_SWSET, 32'h0100_0000);
        for (int m = 0; m < 5; m++) begin
            wr(ism_pkg::OFS_MASK, 32'(m));
            repeat (3) @(posedge clock);
            #1;
            check("req_mask", 32'(irq_req), m < 2 ? 32'h1 : 32'h0);
        end
        check("irq_out", 32'(irq_out), 32'h0000_0001);
        wr(ism_pkg::OFS_SWSET, 32'h0200_0000);
        wr(ism_pkg::OFS_MASK, 32'h0000_0003);
        exp_q.push_back(6'd25);
        drain();
        rd_chk("status", ism_pkg::OFS_STATUS, 32'h0100_0000);
        wr(ism_pkg::OFS_MASK, 32'h0000_0000);
        exp_q.push_back(6'd24);
        drain();
        $display("test priority done");
        wr(ism_pkg::OFS_SWSET, 32'h8000_0000);
        sys_exc <= 2'h3;
        @(posedge clock);
        sys_exc <= 2'h0;
        rd_chk("exc", ism_pkg::OFS_EXC, 32'h0000_0003);
        exp_q = '{6'd32, 6'd33, 6'd31};
        drain();
        $display("test exceptions done");
        wr(ism_pkg::OFS_ENABLE, 32'h0000_0000);
        wr(ism_pkg::OFS_SWSET, 32'hFFFF_FFFF);
        rd_chk("status", ism_pkg::OFS_STATUS, ism_pkg::LINE_VALID);
        check("irq_out", {irq_out, irq_req, 30'h0}, 32'h0000_0000);
        wr(ism_pkg::OFS_CLEAR, 32'hFFFF_FFFF);
        rd_chk("status", ism_pkg::OFS_STATUS, 32'h0000_0000);
        sys_exc <= 2'h2;
        @(posedge clock);
        sys_exc <= 2'h0;
        wr(ism_pkg::OFS_EXC, 32'h0000_0002);
        rd_chk("exc_clr", ism_pkg::OFS_EXC, 32'h0000_0000);
        $display("test software set done");
        conclude();
    end
endmodule
